/* rtl/ucs_pkg.sv */
package ucs_pkg;

	// Bus geometry: register index sits in adr[ADR_W-1:2]
	localparam int ADR_W = 18;

	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_STATUS = 16'h4100;
	localparam logic [15:0] IDX_TX     = 16'h4101;
	localparam logic [15:0] IDX_RX     = 16'h4102;
	localparam logic [15:0] IDX_MODE   = 16'h4103;
	localparam logic [15:0] IDX_CTRL   = 16'h4104;

	// line_status bit positions
	localparam int ST_TXC  = 7;
	localparam int ST_FRM  = 6;
	localparam int ST_PAR  = 5;
	localparam int ST_OVR  = 4;
	localparam int ST_RX2  = 3;
	localparam int ST_BUSY = 2;
	localparam int ST_RXA  = 1;
	localparam int ST_TXE  = 0;

	// frame_format bit positions
	localparam int MD_CHLEN = 4;
	localparam int MD_PEN   = 3;
	localparam int MD_ODD   = 2;
	localparam int MD_STOP2 = 1;

	// interrupt_control bit positions
	localparam int CT_TXC = 7;
	localparam int CT_ERR = 6;
	localparam int CT_RXF = 5;
	localparam int CT_TXE = 4;
	localparam int CT_THR = 1;

	// Writable bits and values after reset
	localparam logic [7:0] MODE_MASK = 8'h1E;
	localparam logic [7:0] CTRL_MASK = 8'hF2;
	localparam logic [7:0] RST_MODE  = 8'h00;
	localparam logic [7:0] RST_CTRL  = 8'h00;
	localparam logic [7:0] RST_BYTE  = 8'h00;

	// Clock cycles per serial bit
	localparam int DEF_CLKS_PER_BIT = 16;

	typedef enum logic [2:0] {
		UCS_IDLE  = 3'h0,
		UCS_START = 3'h1,
		UCS_DATA  = 3'h3,
		UCS_PAR   = 3'h2,
		UCS_STOP  = 3'h6
	} ucs_state_t;

endpackage

/* rtl/ucs_uart_channel.sv */
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
// How it works
// - Transmission-complete flag sets when a frame ends; writing one clears it.
// - Status bit 3 is high while two received bytes are held.
// - Status bit 1 is high while at least one received byte is held.
// - Status bit 0 is high when transmit buffer can take a byte; resets high.
// - Receive register returns bytes oldest first; each read advances while a byte is held.
// - Receive register is 8-bit read-only, resets zero; 7-bit mode MSB in bit 6.
// - Control bit 7 enables interrupt on transmission complete.
// - Control bit 6 enables interrupt on framing, parity or overrun flags.
// - Control bit 5 enables interrupt when receive buffer reaches fill condition.
// - Control bit 4 enables interrupt while transmit buffer is empty.
// - Control bit 1 picks fill condition: zero one byte, one two bytes.
module ucs_uart_channel
	import ucs_pkg::*;
#(
	parameter int CLKS_PER_BIT = DEF_CLKS_PER_BIT
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Wishbone classic slave
	input  wire logic             cyc_i,
	input  wire logic             stb_i,
	input  wire logic             we_i,
	input  wire logic [ADR_W-1:0] adr_i,
	input  wire logic [3:0]       sel_i,
	input  wire logic [31:0]      dat_i,
	output logic      [31:0]      dat_o,
	output logic                  ack_o,
	// Serial line
	input  wire logic             rxd_i,
	output logic                  txd_o,
	// Interrupt request
	output logic                  irq_o
);

	// Below 4 the half-bit check lands on the tick; above, the counter wraps
	generate
		if (CLKS_PER_BIT < 4 || CLKS_PER_BIT > 65535) begin : g_bad_cpb
			$error("CLKS_PER_BIT out of range");
		end
	endgenerate

	localparam logic [15:0] BIT_LAST = 16'(CLKS_PER_BIT - 1);
	localparam logic [15:0] BIT_HALF = 16'(CLKS_PER_BIT / 2 - 1);

	function automatic logic reg_hit(input logic [ADR_W-1:0] adr, input logic [15:0] idx);
		reg_hit = (adr[ADR_W-1:2] == idx) && (adr[1:0] == 2'b00);
	endfunction

	logic [7:0]  mode;
	logic [7:0]  ctrl;
	logic [7:4]  sticky;
	logic [7:4]  next_sticky;
	logic [7:0]  tx_buf;
	logic        tx_full;
	ucs_state_t  tx_state;
	logic [15:0] tx_baud;
	logic [2:0]  tx_bit;
	logic [7:0]  tx_sh;
	logic        tx_par;
	logic        tx_stop2;
	ucs_state_t  rx_state;
	logic [15:0] rx_baud;
	logic [2:0]  rx_bit;
	logic [7:0]  rx_sh;
	logic        rx_par;
	logic        rx_s1;
	logic        rx_s2;
	logic [7:0]  rx_mem [2];
	logic [1:0]  rx_count;
	logic        rx_rd;

	// Bus decode
	wire         req       = cyc_i & stb_i & ~ack_o;
	wire         wr_lane   = req & we_i & sel_i[0];
	wire         hit_st    = reg_hit(adr_i, IDX_STATUS);
	wire         hit_tx    = reg_hit(adr_i, IDX_TX);
	wire         hit_rx    = reg_hit(adr_i, IDX_RX);
	wire         hit_md    = reg_hit(adr_i, IDX_MODE);
	wire         hit_ct    = reg_hit(adr_i, IDX_CTRL);
	wire         wr_st     = wr_lane & hit_st;
	wire         wr_tx     = wr_lane & hit_tx;
	wire         wr_md     = wr_lane & hit_md;
	wire         wr_ct     = wr_lane & hit_ct;
	wire         rx_pop    = req & ~we_i & hit_rx & (rx_count != 2'd0);

	// Serial machine status
	wire         tx_tick   = (tx_baud == BIT_LAST);
	wire         rx_tick   = (rx_baud == BIT_LAST);
	wire         tx_load   = (tx_state == UCS_IDLE) & tx_full;
	wire         tx_done   = (tx_state == UCS_STOP) & tx_tick & ~tx_stop2;
	wire [2:0]   bit_last  = mode[MD_CHLEN] ? 3'd7 : 3'd6;
	wire [7:0]   rx_byte   = mode[MD_CHLEN] ? rx_sh : {1'b0, rx_sh[7:1]};
	wire         rx_end    = (rx_state == UCS_STOP) & rx_tick;
	wire         rx_push   = rx_end & (rx_count != 2'd2);
	wire         rx_ovr    = rx_end & (rx_count == 2'd2);
	wire         rx_frm    = rx_end & ~rx_s2;
	wire         rx_perr   = (rx_state == UCS_PAR) & rx_tick & (rx_par != rx_s2);
	wire         rx_wp     = rx_rd ^ rx_count[0];

	// Status view
	wire         tx_empty  = ~tx_full;
	wire         rx_avail  = (rx_count != 2'd0);
	wire         rx_two    = (rx_count == 2'd2);
	wire         tx_busy   = (tx_state != UCS_IDLE);
	wire         rx_fill   = ctrl[CT_THR] ? rx_two : rx_avail;
	wire [7:0]   set_vec   = {tx_done, rx_frm, rx_perr, rx_ovr, 4'h0};
	wire [7:0]   status    = {sticky[7:4], rx_two, tx_busy, rx_avail, tx_empty};
	wire [7:0]   rdata     = hit_st ? status :
	                         hit_tx ? tx_buf :
	                         hit_rx ? rx_mem[rx_rd] :
	                         hit_md ? (mode & MODE_MASK) :
	                         hit_ct ? (ctrl & CTRL_MASK) : 8'h00;
	wire         next_irq  = (ctrl[CT_TXC] & sticky[ST_TXC])
	                       | (ctrl[CT_ERR] & |sticky[ST_FRM:ST_OVR])
	                       | (ctrl[CT_RXF] & rx_fill)
	                       | (ctrl[CT_TXE] & tx_empty);

	// Single-cycle answer; unmapped reads give zero, unmapped writes vanish
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
			irq_o <= 1'b0;
		end else begin
			ack_o <= req;
			dat_o <= req ? {24'h00_0000, rdata} : 32'h0000_0000;
			irq_o <= next_irq;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode <= RST_MODE;
			ctrl <= RST_CTRL;
		end else begin
			if (wr_md)
				mode <= dat_i[7:0] & MODE_MASK;
			if (wr_ct)
				ctrl <= dat_i[7:0] & CTRL_MASK;
		end
	end

	// Sticky flags: a new event beats a same-cycle clear
	genvar k;
	generate
		for (k = ST_OVR; k <= ST_TXC; k++) begin : g_sticky
			assign next_sticky[k] = set_vec[k] | (sticky[k] & ~(wr_st & dat_i[k]));
		end
	endgenerate

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			sticky <= 4'h0;
		else
			sticky <= next_sticky;
	end

	// Transmit holding buffer; a write while full overwrites the pending byte
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_buf  <= RST_BYTE;
			tx_full <= 1'b0;
		end else begin
			if (wr_tx)
				tx_buf <= dat_i[7:0];
			tx_full <= wr_tx | (tx_full & ~tx_load);
		end
	end

	// Transmit shifter, LSB first
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_state <= UCS_IDLE;
			tx_baud  <= 16'h0000;
			tx_bit   <= 3'd0;
			tx_sh    <= 8'h00;
			tx_par   <= 1'b0;
			tx_stop2 <= 1'b0;
			txd_o    <= 1'b1;
		end else begin
			tx_baud <= (tx_tick || tx_state == UCS_IDLE) ? 16'h0000 : tx_baud + 16'h0001;
			case (tx_state)
				UCS_IDLE: begin
					if (tx_full) begin
						tx_state <= UCS_START;
						txd_o    <= 1'b0;
						tx_sh    <= tx_buf;
						tx_bit   <= 3'd0;
						tx_par   <= mode[MD_ODD];
						tx_stop2 <= mode[MD_STOP2];
					end
				end
				UCS_START: begin
					if (tx_tick) begin
						tx_state <= UCS_DATA;
						txd_o    <= tx_sh[0];
						tx_par   <= tx_par ^ tx_sh[0];
						tx_sh    <= {1'b0, tx_sh[7:1]};
					end
				end
				UCS_DATA: begin
					if (tx_tick) begin
						if (tx_bit == bit_last) begin
							tx_state <= mode[MD_PEN] ? UCS_PAR : UCS_STOP;
							txd_o    <= mode[MD_PEN] ? tx_par : 1'b1;
						end else begin
							tx_bit <= tx_bit + 3'd1;
							txd_o  <= tx_sh[0];
							tx_par <= tx_par ^ tx_sh[0];
							tx_sh  <= {1'b0, tx_sh[7:1]};
						end
					end
				end
				UCS_PAR: begin
					if (tx_tick) begin
						tx_state <= UCS_STOP;
						txd_o    <= 1'b1;
					end
				end
				UCS_STOP: begin
					if (tx_tick) begin
						if (tx_stop2)
							tx_stop2 <= 1'b0;
						else
							tx_state <= UCS_IDLE;
					end
				end
				default: begin
					tx_state <= UCS_IDLE;
					txd_o    <= 1'b1;
				end
			endcase
		end
	end

	// Line input synchroniser
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
		end else begin
			rx_s1 <= rxd_i;
			rx_s2 <= rx_s1;
		end
	end

	// Receiver samples mid-bit; only the first stop bit is checked
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_state <= UCS_IDLE;
			rx_baud  <= 16'h0000;
			rx_bit   <= 3'd0;
			rx_sh    <= 8'h00;
			rx_par   <= 1'b0;
		end else begin
			rx_baud <= (rx_tick || rx_state == UCS_IDLE) ? 16'h0000 : rx_baud + 16'h0001;
			case (rx_state)
				UCS_IDLE: begin
					if (!rx_s2)
						rx_state <= UCS_START;
				end
				UCS_START: begin
					if (rx_baud == BIT_HALF) begin
						rx_baud  <= 16'h0000;
						rx_bit   <= 3'd0;
						rx_par   <= mode[MD_ODD];
						rx_state <= rx_s2 ? UCS_IDLE : UCS_DATA;  // Glitch rejects
					end
				end
				UCS_DATA: begin
					if (rx_tick) begin
						rx_sh  <= {rx_s2, rx_sh[7:1]};
						rx_par <= rx_par ^ rx_s2;
						rx_bit <= rx_bit + 3'd1;
						if (rx_bit == bit_last)
							rx_state <= mode[MD_PEN] ? UCS_PAR : UCS_STOP;
					end
				end
				UCS_PAR: begin
					if (rx_tick)
						rx_state <= UCS_STOP;
				end
				UCS_STOP: begin
					if (rx_tick)
						rx_state <= UCS_IDLE;
				end
				default: rx_state <= UCS_IDLE;
			endcase
		end
	end

	// Two-byte receive buffer; a byte arriving when full is dropped
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_mem[0] <= RST_BYTE;
			rx_mem[1] <= RST_BYTE;
			rx_count  <= 2'd0;
			rx_rd     <= 1'b0;
		end else begin
			if (rx_push)
				rx_mem[rx_wp] <= rx_byte;
			if (rx_pop)
				rx_rd <= ~rx_rd;
			rx_count <= rx_count + {1'b0, rx_push} - {1'b0, rx_pop};
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_bus_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack held beyond one cycle");
	a_bus_ack_follow: assert property (req |=> ack_o)
		else $error("request not answered next cycle");
	a_txc_flag_set: assert property (tx_done |=> sticky[ST_TXC])
		else $error("completion flag not set");
	a_txc_flag_hold: assert property (sticky[ST_TXC] && !(wr_st && dat_i[ST_TXC])
		|=> sticky[ST_TXC])
		else $error("completion flag lost without clear");
	a_rx_second_byte: assert property (rx_count == 2'd1 && rx_push && !rx_pop
		|=> status[ST_RX2] && status[ST_RXA])
		else $error("second byte not flagged");
	a_rx_drain_empty: assert property (rx_count == 2'd1 && rx_pop && !rx_push
		|=> !status[ST_RXA])
		else $error("ready flag stuck after drain");
	a_tx_buf_full: assert property (wr_tx |=> !status[ST_TXE])
		else $error("empty flag stuck after write");
	a_rx_read_order: assert property (rx_pop |=> rx_rd != $past(rx_rd))
		else $error("read did not advance");
	a_irq_txc_on: assert property (ctrl[CT_TXC] && sticky[ST_TXC] |=> irq_o)
		else $error("completion interrupt missing");
	a_irq_err_on: assert property (ctrl[CT_ERR] && sticky[ST_OVR] |=> irq_o)
		else $error("error interrupt missing");
	a_irq_fill_one: assert property (ctrl[CT_RXF] && !ctrl[CT_THR] && rx_avail
		|=> irq_o)
		else $error("fill interrupt missing");
	a_irq_quiet: assert property (ctrl == 8'h00 |=> !irq_o)
		else $error("interrupt while all disabled");
	a_tx_start_bit: assert property (tx_load |=> !txd_o && status[ST_BUSY]
		&& tx_state == UCS_START)
		else $error("frame did not begin");
	a_tx_stop_high: assert property (tx_state == UCS_STOP |-> txd_o)
		else $error("stop bit not high");

	c_frame_sent: cover property (tx_done);
	c_two_held: cover property (rx_two && rx_pop);
	c_overrun: cover property (rx_ovr);
	c_parity_err: cover property (rx_perr);

endmodule // ucs_uart_channel

/* testbench/ucs_remote.sv */
`timescale 1ns/1ps
module ucs_remote #(
	parameter int CPB = 4
) (
	// Clock
	input  wire logic clk_i,
	// Serial line
	input  wire logic txd_i,
	output logic      rxd_o
);
	logic [8:0] got;
	int         frames = 0;
	// Nine when the frame carries a parity bit
	int         nbits  = 8;

	// Line idles high, as the pull-up would leave it
	initial rxd_o = 1'b1;

	// A stop of zero makes a deliberately broken frame
	task automatic send(input logic [8:0] v, input int n, input logic stop);
		@(posedge clk_i);
		rxd_o <= 1'b0;
		repeat (CPB) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			rxd_o <= v[i];
			repeat (CPB) @(posedge clk_i);
		end
		rxd_o <= stop;
		repeat (CPB) @(posedge clk_i);
		rxd_o <= 1'b1;
		repeat (3 * CPB) @(posedge clk_i);
	endtask

	// Samples mid-bit, LSB first, data then any parity bit
	always begin
		@(negedge txd_i);
		repeat (CPB / 2) @(posedge clk_i);
		for (int i = 0; i < nbits; i++) begin
			repeat (CPB) @(posedge clk_i);
			got[i] = txd_i;
		end
		repeat (CPB) @(posedge clk_i);
		frames++;
	end
endmodule // ucs_remote

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import ucs_pkg::*;
	logic             clk_i = 1'b0;
	logic             rst_i = 1'b1;
	logic             cyc = 1'b0;
	logic             stb = 1'b0;
	logic             we = 1'b0;
	logic [ADR_W-1:0] adr = '0;
	logic [3:0]       sel = 4'h0;
	logic [31:0]      dat = '0;
	logic [31:0]      dat_o;
	logic             ack_o, txd_o, irq_o, rxd;
	logic [7:0]       q, d, e;
	int               num_errors = 0;
	int               comparisons = 0;
	int               seed = 61221;
	int               f;

	ucs_uart_channel #(.CLKS_PER_BIT(4)) i_ucs_uart_channel (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
		.dat_o(dat_o), .ack_o(ack_o), .rxd_i(rxd), .txd_o(txd_o), .irq_o(irq_o));
	ucs_remote #(.CPB(4)) i_ucs_remote (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd));

	initial begin
		forever #2 clk_i = ~clk_i;
	end

	task wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task chk(input logic [7:0] g, input logic [7:0] x);
		comparisons++;
		if (g !== x) begin
			num_errors++;
			$display("wrong value at %0t: got %h want %h", $time, g, x);
		end
	endtask

	function automatic logic par_of(input logic [7:0] v, input logic odd);
		par_of = (^v) ^ odd;
	endfunction

	// Master never assumes a latency; ack or the 20-cycle bound ends the wait
	task bus(input logic w, input logic [15:0] idx, input logic [7:0] v);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'h1;
		adr <= {idx, 2'b00};
		dat <= {24'h0, v};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		q = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) begin
			num_errors++;
			wrap_up;
		end
	endtask

	task rchk(input logic [15:0] idx, input logic [7:0] x);
		bus(1'b0, idx, 8'h00);
		chk(q, x);
	endtask

	task rbit(input int b, input logic x);
		bus(1'b0, IDX_STATUS, 8'h00);
		chk({7'h0, q[b]}, {7'h0, x});
	endtask

	// Two edges let the registered request catch up
	task ichk(input logic x);
		repeat (2) @(posedge clk_i);
		chk({7'h0, irq_o}, {7'h0, x});
	endtask

	task wst(input int b);
		int k;
		k = 0;
		do begin
			bus(1'b0, IDX_STATUS, 8'h00);
			k++;
		end while (q[b] !== 1'b1 && k < 100);
		chk({7'h0, q[b]}, 8'h01);
	endtask

	task wfr(input int n);
		int k;
		k = 0;
		while (i_ucs_remote.frames < n && k < 400) begin
			@(posedge clk_i);
			k++;
		end
		if (k >= 400) begin
			num_errors++;
			wrap_up;
		end
	endtask

	initial begin
		repeat (100000) @(posedge clk_i);
		num_errors++;
		wrap_up;
	end

	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk(IDX_STATUS, 8'h01);
		rchk(IDX_RX, RST_BYTE);
		rchk(IDX_MODE, RST_MODE);
		rchk(IDX_CTRL, RST_CTRL);
		bus(1'b1, 16'h4105, 8'hFF);
		rchk(16'h4105, 8'h00);
		ichk(1'b0);
		$display("test reset done");
		repeat (4) begin
			d = 8'($random(seed));
			bus(1'b1, IDX_MODE, d);
			rchk(IDX_MODE, d & MODE_MASK);
			bus(1'b1, IDX_CTRL, d);
			rchk(IDX_CTRL, d & CTRL_MASK);
		end
		bus(1'b1, IDX_MODE, 8'h10);
		bus(1'b1, IDX_CTRL, 8'h10);
		ichk(1'b1);
		bus(1'b1, IDX_CTRL, 8'h80);
		ichk(1'b0);
		$display("test registers done");
		f = i_ucs_remote.frames;
		d = 8'($random(seed));
		e = 8'($random(seed));
		// Second write lands while the first byte is shifting
		bus(1'b1, IDX_TX, d);
		bus(1'b1, IDX_TX, e);
		rbit(ST_TXE, 1'b0);
		rbit(ST_BUSY, 1'b1);
		wfr(f + 1);
		chk(i_ucs_remote.got[7:0], d);
		wfr(f + 2);
		chk(i_ucs_remote.got[7:0], e);
		wst(ST_TXC);
		rbit(ST_BUSY, 1'b0);
		rbit(ST_TXE, 1'b1);
		ichk(1'b1);
		bus(1'b1, IDX_STATUS, 8'h80);
		rbit(ST_TXC, 1'b0);
		ichk(1'b0);
		$display("test transmit done");
		bus(1'b1, IDX_CTRL, 8'h22);
		d = 8'($random(seed));
		e = 8'($random(seed));
		i_ucs_remote.send(d, 8, 1'b1);
		rbit(ST_RXA, 1'b1);
		rbit(ST_RX2, 1'b0);
		ichk(1'b0);
		i_ucs_remote.send(e, 8, 1'b1);
		rbit(ST_RX2, 1'b1);
		ichk(1'b1);
		bus(1'b1, IDX_CTRL, 8'h40);
		ichk(1'b0);
		i_ucs_remote.send(8'h5A, 8, 1'b1);
		rbit(ST_OVR, 1'b1);
		ichk(1'b1);
		rchk(IDX_RX, d);
		rbit(ST_RX2, 1'b0);
		rchk(IDX_RX, e);
		rbit(ST_RXA, 1'b0);
		bus(1'b1, IDX_STATUS, 8'h10);
		ichk(1'b0);
		$display("test receive done");
		// Odd parity, two stops: busy still high while the second stop runs
		bus(1'b1, IDX_MODE, 8'h1E);
		i_ucs_remote.nbits = 9;
		f = i_ucs_remote.frames;
		d = 8'($random(seed));
		bus(1'b1, IDX_TX, d);
		wfr(f + 1);
		rbit(ST_BUSY, 1'b1);
		chk(i_ucs_remote.got[7:0], d);
		chk({7'h0, i_ucs_remote.got[8]}, {7'h0, par_of(d, 1'b1)});
		i_ucs_remote.nbits = 8;
		e = 8'($random(seed));
		i_ucs_remote.send({par_of(e, 1'b1), e}, 9, 1'b1);
		rbit(ST_PAR, 1'b0);
		rchk(IDX_RX, e);
		i_ucs_remote.send({~par_of(e, 1'b1), e}, 9, 1'b1);
		rbit(ST_PAR, 1'b1);
		ichk(1'b1);
		rchk(IDX_RX, e);
		bus(1'b1, IDX_STATUS, 8'h20);
		rbit(ST_PAR, 1'b0);
		$display("test parity done");
		bus(1'b1, IDX_MODE, 8'h00);
		bus(1'b1, IDX_CTRL, 8'h20);
		d = 8'($random(seed));
		i_ucs_remote.send(d, 7, 1'b1);
		ichk(1'b1);
		rchk(IDX_RX, {1'b0, d[6:0]});
		ichk(1'b0);
		// Broken stop goes last: the low line may fake a start
		i_ucs_remote.send(d, 7, 1'b0);
		rbit(ST_FRM, 1'b1);
		$display("test seven bit done");
		wrap_up;
	end
endmodule // tb_top
